// ===== shared/fpc_pkg.sv
`default_nettype none
package fpc_pkg;
	// ***************************************************
	// Bus widths
	// ***************************************************
	localparam int FPC_AW = 18;
	localparam int FPC_DW = 16;

	// ***************************************************
	// Command codes and status fields
	// ***************************************************
	localparam logic [7:0] FPC_CMD_READ_ARRAY = 8'hFF;
	localparam logic [7:0] FPC_CMD_READ_STATUS = 8'h70;
	localparam logic [7:0] FPC_CMD_CLEAR_STATUS = 8'h50;
	localparam int FPC_SR_READY_BIT = 7;

	// ***************************************************
	// Timing at 100 MHz
	// ***************************************************
	localparam int FPC_CLK_PERIOD_NS = 10;
	localparam int FPC_RELEASE_TO_DATA_NS = 300;
	localparam int FPC_RELEASE_CYC = (FPC_RELEASE_TO_DATA_NS
		+ FPC_CLK_PERIOD_NS - 1) / FPC_CLK_PERIOD_NS;
	localparam int FPC_WE_PULSE_NS = 50;
	localparam int FPC_WE_CYC = (FPC_WE_PULSE_NS + FPC_CLK_PERIOD_NS - 1)
		/ FPC_CLK_PERIOD_NS;
	localparam int FPC_ACCESS_NS = 120;
	localparam int FPC_ACCESS_CYC = (FPC_ACCESS_NS + FPC_CLK_PERIOD_NS - 1)
		/ FPC_CLK_PERIOD_NS;
	localparam int FPC_CNT_W = 6;

	// ***************************************************
	// Host sequencer states
	// ***************************************************
	typedef enum logic [3:0] {
		FPC_PWRDN,
		FPC_RECOVER,
		FPC_IDLE,
		FPC_WR_SETUP,
		FPC_WR_PULSE,
		FPC_WR_HOLD,
		FPC_RD_ACCESS,
		FPC_RD_DONE
	} fpc_state_e;
endpackage
`default_nettype wire

// ===== shared/fpc_tmr_if.sv
`default_nettype none
interface fpc_tmr_if;
	import fpc_pkg::*;
	logic load;
	logic [FPC_CNT_W-1:0] count;
	logic done;
	modport owner (output load, output count, input done);
	modport timer (input load, input count, output done);
endinterface
`default_nettype wire

// ===== design/fpc_timer.sv
`default_nettype none
// ***************************************************
// Cycle timer: done pulses when loaded count expires
// ***************************************************
module fpc_timer
	import fpc_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Control
	fpc_tmr_if.timer tmr
);
	logic [FPC_CNT_W-1:0] cnt_ff, nxt_cnt;
	logic done_ff, nxt_done;

	// Reload on request, otherwise count down to zero, pulsing done on the step from one
	always_comb begin
		nxt_cnt = cnt_ff;
		nxt_done = 1'b0;
		if (tmr.load) begin
			nxt_cnt = tmr.count;
		end else if (cnt_ff == FPC_CNT_W'(1)) begin
			nxt_cnt = '0;
			nxt_done = 1'b1;
		end else if (cnt_ff != '0) begin
			nxt_cnt = cnt_ff - FPC_CNT_W'(1);
		end
	end

	// Register stage
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			cnt_ff <= '0;
			done_ff <= 1'b0;
		end else begin
			cnt_ff <= nxt_cnt;
			done_ff <= nxt_done;
		end
	end

	assign tmr.done = done_ff;
endmodule
`default_nettype wire

// ===== design/fpc_host.sv
// ***************************************************
// Summary of operation
// - Drive powerdown-reset from system reset
// - Assert chip select before trusting data
// - Write needs both WE and CE low
// - Issue Read Array after program or erase (the user writes FF itself; the host does not)
// - Read Array command is byte FF
// ***************************************************
`default_nettype none
module fpc_host
	import fpc_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// User request side
	input wire logic req_valid,
	input wire logic req_write,
	input wire logic [FPC_AW-1:0] req_addr,
	input wire logic [FPC_DW-1:0] req_wdata,
	output logic req_ready,
	output logic rsp_valid,
	output logic [FPC_DW-1:0] rsp_rdata,
	output logic flash_ready,
	// Flash pins
	output logic powerdown_reset_n,
	output logic ce_n,
	output logic oe_n,
	output logic we_n,
	output logic [FPC_AW-1:0] addr,
	input wire logic [FPC_DW-1:0] dq_in,
	output logic [FPC_DW-1:0] dq_out,
	output logic dq_oe_n
);
	fpc_tmr_if tmr();
	fpc_state_e state_ff, nxt_state;
	logic rpn_ff, nxt_rpn, ce_ff, nxt_ce, oe_ff, nxt_oe, we_ff, nxt_we;
	logic dqoe_ff, nxt_dqoe, rdy_ff, nxt_rdy, rv_ff, nxt_rv, fr_ff, nxt_fr;
	logic [FPC_AW-1:0] a_ff, nxt_a;
	logic [FPC_DW-1:0] d_ff, nxt_d, rd_ff, nxt_rd;

	fpc_timer u_tmr (
		.clk(clk),
		.reset(reset),
		.tmr(tmr.timer)
	);

	function automatic logic [FPC_CNT_W-1:0] cyc(input int n);
		cyc = FPC_CNT_W'(n);
	endfunction

	// ***************************************************
	// Sequencer: reset, recovery, write and read cycles
	// ***************************************************
	always_comb begin
		nxt_state = state_ff;
		nxt_rpn = rpn_ff;
		nxt_ce = ce_ff;
		nxt_oe = oe_ff;
		nxt_we = we_ff;
		nxt_dqoe = dqoe_ff;
		nxt_rdy = 1'b0;
		nxt_rv = 1'b0;
		nxt_fr = fr_ff;
		nxt_a = a_ff;
		nxt_d = d_ff;
		nxt_rd = rd_ff;
		tmr.load = 1'b0;
		tmr.count = '0;
		case (state_ff)
			FPC_PWRDN: begin
				// Release one cycle after system reset drops
				nxt_rpn = 1'b1;
				tmr.load = 1'b1;
				tmr.count = cyc(FPC_RELEASE_CYC);
				nxt_state = FPC_RECOVER;
			end
			FPC_RECOVER: begin
				// No access before data is guaranteed valid
				if (tmr.done) begin
					nxt_fr = 1'b1; // Device in array read mode
					nxt_rdy = 1'b1;
					nxt_state = FPC_IDLE;
				end
			end
			FPC_IDLE: begin
				// Deselected while idle lets the device stand
				if (req_valid && req_write) begin
					// User writes FF itself after program or erase
					nxt_a = req_addr;
					nxt_d = req_wdata; // Low byte carries the command
					nxt_ce = 1'b0;
					nxt_dqoe = 1'b0;
					nxt_state = FPC_WR_SETUP;
				end else if (req_valid) begin
					// Fresh select and address per read
					nxt_a = req_addr;
					nxt_ce = 1'b0;
					nxt_oe = 1'b0;
					tmr.load = 1'b1;
					tmr.count = cyc(FPC_ACCESS_CYC);
					nxt_state = FPC_RD_ACCESS;
				end else begin
					nxt_rdy = 1'b1;
				end
			end
			FPC_WR_SETUP: begin
				// WE falls only with CE already low
				nxt_we = 1'b0;
				tmr.load = 1'b1;
				tmr.count = cyc(FPC_WE_CYC);
				nxt_state = FPC_WR_PULSE;
			end
			FPC_WR_PULSE: begin
				if (tmr.done) begin
					nxt_we = 1'b1; // Command latched on WE rise
					nxt_state = FPC_WR_HOLD;
				end
			end
			FPC_WR_HOLD: begin
				// Both strobes high inhibits stray writes
				nxt_ce = 1'b1;
				nxt_dqoe = 1'b1;
				nxt_rdy = 1'b1;
				nxt_state = FPC_IDLE;
			end
			FPC_RD_ACCESS: begin
				if (tmr.done) begin
					nxt_rd = dq_in;
					nxt_rv = 1'b1;
					nxt_state = FPC_RD_DONE;
				end
			end
			FPC_RD_DONE: begin
				// Drop select so the device enters standby
				nxt_ce = 1'b1;
				nxt_oe = 1'b1;
				nxt_rdy = 1'b1;
				nxt_state = FPC_IDLE;
			end
			default: begin
				nxt_state = FPC_PWRDN;
			end
		endcase
	end

	// ***************************************************
	// Registers; reset holds the flash in power-down
	// ***************************************************
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			state_ff <= FPC_PWRDN;
			rpn_ff <= 1'b0; // Aborts work, clears status
			ce_ff <= 1'b1;
			oe_ff <= 1'b1;
			we_ff <= 1'b1;
			dqoe_ff <= 1'b1;
			rdy_ff <= 1'b0;
			rv_ff <= 1'b0;
			fr_ff <= 1'b0;
			a_ff <= '0;
			d_ff <= '0;
			rd_ff <= '0;
		end else begin
			state_ff <= nxt_state;
			rpn_ff <= nxt_rpn;
			ce_ff <= nxt_ce;
			oe_ff <= nxt_oe;
			we_ff <= nxt_we;
			dqoe_ff <= nxt_dqoe;
			rdy_ff <= nxt_rdy;
			rv_ff <= nxt_rv;
			fr_ff <= nxt_fr;
			a_ff <= nxt_a;
			d_ff <= nxt_d;
			rd_ff <= nxt_rd;
		end
	end

	// Pins straight from flip-flops
	assign powerdown_reset_n = rpn_ff;
	assign ce_n = ce_ff;
	assign oe_n = oe_ff;
	assign we_n = we_ff;
	assign addr = a_ff;
	assign dq_out = d_ff;
	assign dq_oe_n = dqoe_ff;
	assign req_ready = rdy_ff;
	assign rsp_valid = rv_ff;
	assign rsp_rdata = rd_ff;
	assign flash_ready = fr_ff;
endmodule
`default_nettype wire

// ===== verification/fpc_flash_model.sv
`default_nettype none
// ***************************************************
// Behavioural flash device on the far side of the pins
// ***************************************************
module fpc_flash_model
	import fpc_pkg::*;
(
	// Control pins
	input wire logic powerdown_reset_n,
	input wire logic ce_n,
	input wire logic oe_n,
	input wire logic we_n,
	// Address and data
	input wire logic [FPC_AW-1:0] addr,
	input wire logic [FPC_DW-1:0] dq_out,
	input wire logic dq_oe_n,
	output logic [FPC_DW-1:0] dq_in
);
	timeunit 1ns;
	timeprecision 1ps;
	logic status_mode;
	logic awake;
	logic drive;
	logic [FPC_DW-1:0] last;
	initial begin
		status_mode = 1'b0;
		awake = 1'b0;
		last = 16'h0000;
	end
	// Reset pin low: all off, status cleared, back in array mode
	always @(negedge powerdown_reset_n) begin
		status_mode = 1'b0;
		awake = 1'b0;
	end
	// Data is only trusted once the recovery time has run out
	always @(posedge powerdown_reset_n) begin
		#300 awake = powerdown_reset_n;
	end
	// Command taken on the trailing edge of write enable
	always @(posedge we_n) begin
		if (powerdown_reset_n && !ce_n && dq_oe_n === 1'b0) begin
			status_mode = dq_out[7:0] != FPC_CMD_READ_ARRAY;
		end
	end
	// Output drivers; a released bus shows the inverted last word
	assign drive = awake && !ce_n && !oe_n;
	always @* begin
		if (drive) begin
			last = status_mode ? 16'h0080 : addr[15:0] ^ 16'h5a5a;
		end
	end
	assign dq_in = drive ? last : ~last;
endmodule
`default_nettype wire

// ===== verification/fpc_host_checker.sv
`default_nettype none
// ***************************************************
// Pin discipline of the host sequencer
// ***************************************************
module fpc_host_checker
	import fpc_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// User side
	input wire logic req_valid,
	input wire logic req_write,
	input wire logic req_ready,
	input wire logic rsp_valid,
	input wire logic flash_ready,
	// Flash pins
	input wire logic powerdown_reset_n,
	input wire logic ce_n,
	input wire logic oe_n,
	input wire logic we_n,
	input wire logic dq_oe_n
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [5:0] hi_cnt_ff;
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	// Cycles since the reset pin rose; saturates so it never wraps
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			hi_cnt_ff <= 6'h00;
		end else if (!powerdown_reset_n) begin
			hi_cnt_ff <= 6'h00;
		end else if (hi_cnt_ff != 6'h3f) begin
			hi_cnt_ff <= hi_cnt_ff + 6'h01;
		end
	end
	a_release_wait: assert property ($rose(flash_ready) |->
		int'(hi_cnt_ff) >= FPC_RELEASE_CYC - 1) else $error("ready too soon");
	a_ready_pin_high: assert property (flash_ready |->
		powerdown_reset_n) else $error("ready while pin low");
	a_write_strobes: assert property (!we_n |->
		!ce_n && !dq_oe_n && oe_n) else $error("bad write strobes");
	a_we_width: assert property ($fell(we_n) |->
		!we_n [*5]) else $error("write pulse short");
	a_write_take: assert property (req_valid && req_ready && req_write
		|=> !ce_n && !dq_oe_n) else $error("write not started");
	a_read_take: assert property (req_valid && req_ready && !req_write
		|=> !ce_n && !oe_n && dq_oe_n) else $error("read not started");
	a_rsp_after_read: assert property (rsp_valid |->
		$past(oe_n) == 1'b0) else $error("answer without read");
	a_quiet_in_pwrdn: assert property (!powerdown_reset_n |->
		ce_n && we_n) else $error("strobe during power-down");
	c_write: cover property (!we_n);
	c_read: cover property (rsp_valid);
	c_ready: cover property ($rose(flash_ready));
endmodule
bind fpc_host fpc_host_checker chk (.clk, .reset, .req_valid, .req_write,
	.req_ready, .rsp_valid, .flash_ready, .powerdown_reset_n, .ce_n, .oe_n,
	.we_n, .dq_oe_n);
`default_nettype wire

// ===== verification/test_flash_power_reset_mode_control.sv
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin \
	fail_count++; $display("MISMATCH %0t %h %h", $time, a, b); end end
module test_flash_power_reset_mode_control
	import fpc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, reset, req_valid, req_write, req_ready, rsp_valid;
	logic flash_ready, powerdown_reset_n, ce_n, oe_n, we_n, dq_oe_n;
	logic [FPC_AW-1:0] req_addr, addr;
	logic [FPC_DW-1:0] req_wdata, rsp_rdata, dq_in, dq_out;
	int fail_count = 0;
	int samples_checked = 0;
	fpc_host dut (.clk, .reset, .req_valid, .req_write, .req_addr,
		.req_wdata, .req_ready, .rsp_valid, .rsp_rdata, .flash_ready,
		.powerdown_reset_n, .ce_n, .oe_n, .we_n, .addr, .dq_in, .dq_out,
		.dq_oe_n);
	fpc_flash_model flash (.powerdown_reset_n, .ce_n, .oe_n, .we_n,
		.addr, .dq_out, .dq_oe_n, .dq_in);
	// 100 MHz clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic tick(int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic test_done();
		$display("checked %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	// Bounded wait; a hang counts as a mismatch and ends the run
	task automatic wait_for(ref logic s);
		int i;
		for (i = 0; i < 200 && s !== 1'b1; i++) tick(1);
		if (s !== 1'b1) begin
			fail_count++;
			test_done();
		end
	endtask
	// One request; a read waits for its answer, the caller compares the word
	task automatic access(logic w, logic [FPC_AW-1:0] a,
		logic [FPC_DW-1:0] d);
		wait_for(req_ready);
		req_write = w;
		req_addr = a;
		req_wdata = d;
		req_valid = 1'b1;
		tick(1);
		req_valid = 1'b0;
		// A write has no answer pulse; wait until the strobes are back up
		if (!w) begin
			wait_for(rsp_valid);
		end else begin
			wait_for(req_ready);
		end
	endtask
	// Reset held 8 cycles; the flash pin must follow it
	task automatic t_reset();
		reset = 1'b1;
		tick(8);
		`CHK({powerdown_reset_n, ce_n, we_n}, 3'h3)
		`CHK(powerdown_reset_n, 1'b0)
		reset = 1'b0;
		wait_for(flash_ready);
		`CHK(powerdown_reset_n, 1'b1)
	endtask
	task automatic t_read();
		access(1'b0, 18'h0_0123, 16'h0000);
		`CHK(rsp_rdata, 16'h0123 ^ 16'h5a5a)
		access(1'b0, 18'h3_0124, 16'h0000);
		`CHK(rsp_rdata, 16'h0124 ^ 16'h5a5a)
	endtask
	// Status mode stays until the array command is written
	task automatic t_status();
		access(1'b1, 18'h0_0000, 16'h0070);
		access(1'b0, 18'h0_0055, 16'h0000);
		`CHK(rsp_rdata, 16'h0001 << FPC_SR_READY_BIT)
		access(1'b1, 18'h0_0000, 16'h00ff);
		access(1'b0, 18'h0_0055, 16'h0000);
		`CHK(rsp_rdata, 16'h0055 ^ 16'h5a5a)
	endtask
	// Mid-run reset out of status mode must land in array mode
	task automatic t_reset_mid();
		access(1'b1, 18'h0_0000, 16'h0070);
		access(1'b0, 18'h0_0077, 16'h0000);
		`CHK(rsp_rdata, 16'h0001 << FPC_SR_READY_BIT)
		t_reset();
		access(1'b0, 18'h0_0077, 16'h0000);
		`CHK(rsp_rdata, 16'h0077 ^ 16'h5a5a)
	endtask
	initial begin
		reset = 1'b1;
		req_valid = 1'b0;
		req_write = 1'b0;
		req_addr = 18'h0_0000;
		req_wdata = 16'h0000;
		t_reset();
		t_read();
		t_status();
		t_reset_mid();
		test_done();
	end
endmodule
`undef CHK
`default_nettype wire
